// >>> tb/clock_source_model.sv
// Behavioural model of the clock sources that feed the clock control block.
// Assumes source levels are sampled on pclk; every source toggles on pclk edges.
`timescale 1ns/1ns
`default_nettype none
module clock_source_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic crystal_osc_enable,
  input wire logic pll_power_on,
  output logic internal_rc_osc,
  output logic crystal_osc,
  output logic ext_clock_pin,
  output logic pll_out_clk
);
  int cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      internal_rc_osc <= 1'b0;
      crystal_osc <= 1'b0;
      ext_clock_pin <= 1'b0;
      pll_out_clk <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      // About 20.8 MHz, inside the reference range
      if (cnt % 3 == 2) internal_rc_osc <= !internal_rc_osc;
      // Crystal stands still until enabled; 15.6 MHz
      if (crystal_osc_enable && cnt % 4 == 3) crystal_osc <= !crystal_osc;
      // 12.5 MHz on the pin
      if (cnt % 5 == 4) ext_clock_pin <= !ext_clock_pin;
      pll_out_clk <= pll_power_on ? !pll_out_clk : 1'b0;
    end
  end
endmodule // clock_source_model
`default_nettype wire

// >>> tb/system_clock_pll_control_tb_top.sv
// Self-checking bench for the clock control block.
// Assumes the APB timing and register map of the design, with a short lock count.
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_cfg.svh"
module system_clock_pll_control_tb_top;
  localparam int LOCK = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rc, xt, pin, pll, main_clk, pll_power_on, pll_bypass, xt_en, pll_locked;
  logic exp_q[$];
  logic [5:0] pll_mult;
  logic [4:0] pll_div;
  logic [1:0] pll_ref_sel;
  logic [31:0] seed = 32'h4375_bfe4;
  int error_cnt = 0, cmp_count = 0, sel_ref = 0, sel_thru = 0;

  initial forever #4 pclk = ~pclk;

  system_clock_pll_control #(.LOCK_CYCLES(LOCK)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_rc_osc(rc), .crystal_osc(xt), .ext_clock_pin(pin), .pll_out_clk(pll),
    .main_clk(main_clk), .pll_power_on(pll_power_on), .pll_bypass(pll_bypass), .pll_mult(pll_mult),
    .pll_div(pll_div), .pll_ref_sel(pll_ref_sel), .crystal_osc_enable(xt_en), .pll_locked(pll_locked));

  clock_source_model i_src (.pclk(pclk), .presetn(presetn), .crystal_osc_enable(xt_en),
    .pll_power_on(pll_power_on), .internal_rc_osc(rc), .crystal_osc(xt), .ext_clock_pin(pin),
    .pll_out_clk(pll));

  function logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic cur_src();
    if (sel_thru != 0) return pll;
    return (sel_ref == 0) ? rc : (sel_ref == 1) ? xt : pin;
  endfunction

  task give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask

  // Main clock must repeat the selected source one cycle late
  task follow(input int n);
    exp_q.push_back(cur_src());
    repeat (n) begin
      @(posedge pclk);
      chk(32'(main_clk), 32'(exp_q.pop_front()));
      exp_q.push_back(cur_src());
    end
    exp_q.delete();
  endtask

  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end

  initial begin
    int m, code, n;
    int tbl[5];
    logic [31:0] r;
    logic e;
    tbl = '{1, 2, 4, 5, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({pll_power_on, pll_bypass, pll_locked}), 32'h0000_0002);
    chk(32'({pll_mult, pll_div, pll_ref_sel}), 32'({6'h01, 5'h02, 2'h0}));
    follow(12);
    rd(`ADDR_SRC_STAT, 32'h0000_0000);
    rd(`ADDR_PLL_CTRL, 32'h0000_0000);
    for (m = 1; m <= 32; m++) begin
      code = int'(xorshift() & 32'h0000_0003);
      wr(`ADDR_PLL_CFG, 32'(m - 1) | (32'(code) << 5));
      @(posedge pclk);
      chk(32'(pll_mult), 32'(m));
      chk(32'(pll_div), 32'(2 << code));
    end
    rd(`ADDR_PLL_CFG, 32'(31 | (code << 5)));
    rd(`ADDR_FOUT, 32'h0000_2EE0);
    // Loop oscillator kept inside its range for a 12 MHz reference
    m = 13 + int'(xorshift() % 32'h0000_000E);
    wr(`ADDR_PLL_CFG, 32'(m - 1) | (32'(code) << 5));
    wr(`ADDR_PLL_CTRL, 32'h0000_0001);
    n = 0;
    while (pll_locked !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= LOCK - 2 && n <= LOCK + 4), 32'h0000_0001);
    chk(32'({pll_power_on, pll_bypass}), 32'h0000_0002);
    rd(`ADDR_PLL_STAT, 32'h0000_0001);
    rd(`ADDR_FOUT, 32'(12000 * m / (2 << code)));
    wr(`ADDR_PLL_STAT, 32'h0000_0000);
    rd(`ADDR_PLL_STAT, 32'h0000_0001);
    apb(1'b0, 12'h01C, 32'h0000_0000, r, e);
    chk({r[30:0], e}, 32'h0000_0001);
    wr(`ADDR_OSC_CTRL, 32'h0000_0001);
    @(posedge pclk);
    chk(32'(xt_en), 32'h0000_0001);
    foreach (tbl[i]) begin
      wr(`ADDR_SRC_SEL, 32'(tbl[i]));
      sel_ref = tbl[i] & 3;
      sel_thru = tbl[i] >> 2;
      n = 0;
      do begin
        apb(1'b0, `ADDR_SRC_STAT, 32'h0000_0000, r, e);
        n++;
      end while (r[3] !== 1'b0 && n < 20);
      chk(r, 32'(tbl[i]));
      chk(32'(pll_ref_sel), 32'(sel_ref));
      follow(16);
    end
    give_verdict;
  end
endmodule // system_clock_pll_control_tb_top
`default_nettype wire

// >>> verilog/clk_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
// What this block does
// (RULE1) After any reset the main clock runs from the 12 MHz internal RC oscillator.
// (RULE2) After reset the PLL is powered off and bypassed until software enables it.
// (RULE3) PLL multiplier accepts every integer from 1 to 32.
// (RULE4) PLL post-divider divides by 2, 4, 8 or 16 only.
// (RULE5) Software programs the PLL, enables it, waits for lock, then selects it.
// (RULE6) Lock is reported about 100 us after the PLL is enabled.
// (RULE7) Software keeps the PLL reference between 10 MHz and 25 MHz.
// (RULE8) Software keeps the loop oscillator between 156 MHz and 320 MHz.
// (RULE9) Main clock comes from RC or crystal, directly or through the PLL; the code also lets the external pin drive it directly.
// (RULE10) The external clock pin can feed the PLL reference instead of an oscillator.
// (RULE11) External clocks on the pin or crystal input stay at or below 25 MHz.
// (RULE12) Software enables a source and waits for it to settle before selecting it.
// (RULE13) Lock status is readable and source switching never truncates a clock pulse.
`ifndef CLK_CTRL_CFG_SVH
`define CLK_CTRL_CFG_SVH

`define ADDR_PLL_CFG 12'h000
`define ADDR_PLL_CTRL 12'h004
`define ADDR_PLL_STAT 12'h008
`define ADDR_SRC_SEL 12'h00C
`define ADDR_SRC_STAT 12'h010
`define ADDR_OSC_CTRL 12'h014
`define ADDR_FOUT 12'h018

`define MSEL_LSB 0
`define MSEL_W 5
`define PSEL_LSB 5
`define PSEL_W 2
`define SRC_REF_LSB 0
`define SRC_PLL_BIT 2
`define STAT_BUSY_BIT 3

`define MSEL_RESET 5'h00
`define PSEL_RESET 2'h0
`define RC_KHZ 32'h0000_2EE0
`define XTAL_KHZ_DEF 32'h0000_2EE0
`define PIN_KHZ_DEF 32'h0000_2EE0

`define PCLK_MHZ 125
`define LOCK_TIME_US 100
`define LOCK_CYCLES_DEF (`LOCK_TIME_US * `PCLK_MHZ)

`endif

// >>> verilog/clk_ctrl_pkg.sv
// Types shared by the clock control block.
// Assumes nothing beyond the constants header.
package clk_ctrl_pkg;
  typedef enum logic [1:0] {
    REF_RC = 2'b00,
    REF_XTAL = 2'b01,
    REF_PIN = 2'b10
  } ref_src_type;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN = 2'b01,
    SW_ARM = 2'b10
  } sw_state_type;
endpackage

// >>> verilog/pll_lock_model.sv
// Lock model of the system PLL: lock a fixed count of cycles after enable.
// Assumes enable and restart are synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module pll_lock_model #(
  parameter int LOCK_CYCLES = 12500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  output logic locked
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_locked;

  always_comb begin
    next_count = count;
    next_locked = locked;
    if (!enable || restart) begin
      next_count = 16'h0000;
      next_locked = 1'b0;
    end else if (!locked) begin
      if (count == 16'(LOCK_CYCLES - 1)) begin // RULE6
        next_locked = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      locked <= 1'b0;
    end else begin
      count <= next_count;
      locked <= next_locked;
    end
  end

  property p_lock_time;
    @(posedge pclk) disable iff (!presetn)
    $rose(locked) |-> $past(count) == 16'(LOCK_CYCLES - 1) && $past(enable, 1);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock rose before settling count"); // RULE6

  property p_unlock;
    @(posedge pclk) disable iff (!presetn)
    !enable |=> !locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock held while PLL disabled"); // RULE6
endmodule // pll_lock_model
`default_nettype wire

// >>> verilog/system_clock_pll_control.sv
// System clock selection and PLL control with an APB register slave.
// Assumes source clocks arrive as levels sampled on pclk and the PLL analog core is outside.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_cfg.svh"
module system_clock_pll_control
  import clk_ctrl_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CYCLES_DEF,
  parameter logic [31:0] XTAL_KHZ = `XTAL_KHZ_DEF,
  parameter logic [31:0] PIN_KHZ = `PIN_KHZ_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_rc_osc,
  input wire logic crystal_osc,
  input wire logic ext_clock_pin,
  input wire logic pll_out_clk,
  output logic main_clk,
  output logic pll_power_on,
  output logic pll_bypass,
  output logic [5:0] pll_mult,
  output logic [4:0] pll_div,
  output logic [1:0] pll_ref_sel,
  output logic crystal_osc_enable,
  output logic pll_locked
);
  function automatic logic src_level(input logic [1:0] ref_src, input logic thru_pll,
                                     input logic rc, input logic xt, input logic pin,
                                     input logic pl);
    if (thru_pll) begin
      src_level = pl;
    end else begin
      case (ref_src)
        REF_XTAL: src_level = xt;
        REF_PIN: src_level = pin;
        default: src_level = rc;
      endcase
    end
  endfunction

  function automatic logic [31:0] out_khz(input logic [31:0] ref_khz, input logic [4:0] m,
                                          input logic [1:0] p, input logic en);
    logic [31:0] prod;
    prod = ref_khz * ({27'h000_0000, m} + 32'h0000_0001);
    out_khz = en ? (prod >> ({30'h0000_0000, p} + 32'h0000_0001)) : ref_khz;
  endfunction

  logic [4:0] msel;
  logic [1:0] psel_div;
  logic pll_enable;
  logic [1:0] sel_ref;
  logic sel_pll;
  logic xtal_en;
  logic [1:0] active_ref;
  logic active_pll;
  sw_state_type sw_state;
  logic relock;
  logic lock_flag;
  logic [4:0] next_msel;
  logic [1:0] next_psel_div;
  logic next_pll_enable;
  logic [1:0] next_sel_ref;
  logic next_sel_pll;
  logic next_xtal_en;
  logic next_relock;
  logic [1:0] next_active_ref;
  logic next_active_pll;
  sw_state_type next_sw_state;
  logic next_main_clk;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;
  logic wr_take;
  logic mapped;
  logic old_level;
  logic new_level;
  logic [31:0] ref_khz;

  assign access = psel && penable;
  assign wr_take = access && pready && pwrite && !pslverr;

  always_comb begin
    case (paddr)
      `ADDR_PLL_CFG, `ADDR_PLL_CTRL, `ADDR_PLL_STAT, `ADDR_SRC_SEL,
      `ADDR_SRC_STAT, `ADDR_OSC_CTRL, `ADDR_FOUT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    case (pll_ref_sel)
      REF_XTAL: ref_khz = XTAL_KHZ;
      REF_PIN: ref_khz = PIN_KHZ;
      default: ref_khz = `RC_KHZ;
    endcase
  end

  // Register writes and the APB answer, one wait state per access
  always_comb begin
    next_msel = msel;
    next_psel_div = psel_div;
    next_pll_enable = pll_enable;
    next_sel_ref = sel_ref;
    next_sel_pll = sel_pll;
    next_xtal_en = xtal_en;
    next_relock = 1'b0;
    next_pready = access && !pready;
    next_pslverr = access && !pready && !mapped;
    next_prdata = 32'h0000_0000;
    if (wr_take) begin
      case (paddr)
        `ADDR_PLL_CFG: begin
          next_msel = pwdata[`MSEL_LSB +: `MSEL_W]; // RULE3
          next_psel_div = pwdata[`PSEL_LSB +: `PSEL_W]; // RULE4
          next_relock = 1'b1;
        end
        `ADDR_PLL_CTRL: next_pll_enable = pwdata[0]; // RULE2
        `ADDR_SRC_SEL: begin
          if (pwdata[`SRC_REF_LSB +: 2] != 2'b11) begin
            next_sel_ref = pwdata[`SRC_REF_LSB +: 2]; // RULE9 RULE10
          end
          next_sel_pll = pwdata[`SRC_PLL_BIT];
        end
        `ADDR_OSC_CTRL: next_xtal_en = pwdata[0];
        default: next_relock = 1'b0;
      endcase
    end
    if (access && !pready && !pwrite) begin
      case (paddr)
        `ADDR_PLL_CFG: next_prdata = {25'h000_0000, psel_div, msel};
        `ADDR_PLL_CTRL: next_prdata = {31'h0000_0000, pll_enable};
        `ADDR_PLL_STAT: next_prdata = {31'h0000_0000, pll_locked}; // RULE13
        `ADDR_SRC_SEL: next_prdata = {29'h0000_0000, sel_pll, sel_ref};
        `ADDR_SRC_STAT: next_prdata = {28'h000_0000, sw_state != SW_RUN, active_pll, active_ref};
        `ADDR_OSC_CTRL: next_prdata = {31'h0000_0000, xtal_en};
        `ADDR_FOUT: next_prdata = out_khz(ref_khz, msel, psel_div, pll_enable); // RULE3 RULE4
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msel <= `MSEL_RESET;
      psel_div <= `PSEL_RESET;
      pll_enable <= 1'b0; // RULE2
      sel_ref <= REF_RC; // RULE1
      sel_pll <= 1'b0;
      xtal_en <= 1'b0;
      relock <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      msel <= next_msel;
      psel_div <= next_psel_div;
      pll_enable <= next_pll_enable;
      sel_ref <= next_sel_ref;
      sel_pll <= next_sel_pll;
      xtal_en <= next_xtal_en;
      relock <= next_relock;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Analog control outputs follow the registers one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_power_on <= 1'b0; // RULE2
      pll_bypass <= 1'b1; // RULE2
      pll_mult <= 6'h01;
      pll_div <= 5'h02;
      pll_ref_sel <= REF_RC;
      crystal_osc_enable <= 1'b0;
    end else begin
      pll_power_on <= pll_enable;
      pll_bypass <= !pll_enable;
      pll_mult <= {1'b0, msel} + 6'h01; // RULE3
      pll_div <= 5'h02 << psel_div; // RULE4
      pll_ref_sel <= sel_ref; // RULE10
      crystal_osc_enable <= xtal_en;
    end
  end

  pll_lock_model #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) lock_model (
    .pclk(pclk),
    .presetn(presetn),
    .enable(pll_enable),
    .restart(relock),
    .locked(lock_flag)
  );
  assign pll_locked = lock_flag;

  // Glitch-free switch: old source finishes its high phase, output parks low, new source joins low
  assign old_level = src_level(active_ref, active_pll, internal_rc_osc, crystal_osc, ext_clock_pin, pll_out_clk);
  assign new_level = src_level(sel_ref, sel_pll, internal_rc_osc, crystal_osc, ext_clock_pin, pll_out_clk);

  always_comb begin
    next_sw_state = sw_state;
    next_active_ref = active_ref;
    next_active_pll = active_pll;
    next_main_clk = 1'b0;
    case (sw_state)
      SW_RUN: begin
        next_main_clk = old_level; // RULE9 RULE10
        if (sel_ref != active_ref || sel_pll != active_pll) begin
          next_sw_state = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        next_main_clk = old_level && main_clk; // RULE13
        if (!old_level) begin
          next_sw_state = SW_ARM;
        end
      end
      SW_ARM: begin
        if (!new_level) begin // RULE13
          next_active_ref = sel_ref;
          next_active_pll = sel_pll;
          next_sw_state = SW_RUN;
        end
      end
      default: next_sw_state = SW_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= SW_RUN;
      active_ref <= REF_RC; // RULE1
      active_pll <= 1'b0; // RULE2
      main_clk <= 1'b0;
    end else begin
      sw_state <= next_sw_state;
      active_ref <= next_active_ref;
      active_pll <= next_active_pll;
      main_clk <= next_main_clk;
    end
  end

  logic wrote_src;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrote_src <= 1'b0;
    end else if (wr_take && paddr == `ADDR_SRC_SEL) begin
      wrote_src <= 1'b1;
    end
  end

  property p_stay_rc;
    @(posedge pclk) disable iff (!presetn)
    !wrote_src |-> active_ref == REF_RC && !active_pll && sw_state == SW_RUN;
  endproperty
  a_stay_rc: assert property (p_stay_rc) else $error("left RC clock without software select"); // RULE1

  property p_off_bypass;
    @(posedge pclk) disable iff (!presetn)
    !pll_enable |=> pll_bypass && !pll_power_on && !pll_locked;
  endproperty
  a_off_bypass: assert property (p_off_bypass) else $error("PLL not off and bypassed"); // RULE2

  property p_mult_range;
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> pll_mult == {1'b0, $past(msel)} + 6'h01 && pll_mult >= 6'h01 && pll_mult <= 6'h20;
  endproperty
  a_mult_range: assert property (p_mult_range) else $error("multiplier out of 1..32"); // RULE3

  property p_div_set;
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> pll_div == (5'h02 << $past(psel_div)) &&
      (pll_div == 5'h02 || pll_div == 5'h04 || pll_div == 5'h08 || pll_div == 5'h10);
  endproperty
  a_div_set: assert property (p_div_set) else $error("post-divider not 2, 4, 8 or 16"); // RULE4

  property p_rc_direct;
    @(posedge pclk) disable iff (!presetn)
    sw_state == SW_RUN && active_ref == REF_RC && !active_pll |=> main_clk == $past(internal_rc_osc);
  endproperty
  a_rc_direct: assert property (p_rc_direct) else $error("RC clock not routed to main clock"); // RULE9

  property p_pll_path;
    @(posedge pclk) disable iff (!presetn)
    sw_state == SW_RUN && active_pll |=> main_clk == $past(pll_out_clk);
  endproperty
  a_pll_path: assert property (p_pll_path) else $error("PLL output not routed to main clock"); // RULE9

  property p_ref_pin;
    @(posedge pclk) disable iff (!presetn)
    wr_take && paddr == `ADDR_SRC_SEL && pwdata[1:0] == REF_PIN |=> ##1 pll_ref_sel == REF_PIN;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("external pin not sent to PLL reference"); // RULE10

  property p_lock_read;
    @(posedge pclk) disable iff (!presetn)
    access && !pready && !pwrite && paddr == `ADDR_PLL_STAT |=> pready && prdata[0] == $past(pll_locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status not readable"); // RULE13

  property p_no_runt;
    @(posedge pclk) disable iff (!presetn)
    sw_state != SW_RUN && !main_clk |=> !main_clk;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("clock pulse started during source switch"); // RULE13
endmodule // system_clock_pll_control
`default_nettype wire
